// ---- hw/adc_auto_sequencer.sv ----
// Operation
// - Converter stays powered down until software clears it
// - Converter clock is 24 MHz over divider+1
// - Noise has capture only; others set then capture
// - Steps run from index zero (index one without noise) to maximum index
// - Noise, left, misc have independent enables
// - Right enable works only with left enabled
// - Set states last set-length crystal ticks
// - Set state drives that channel's converter controls
// - Per-channel resolution selects 8/10/12/14 bits
// - Results are 15-bit, sign extended
// - Settling lasts tsamp converter clock cycles
// - Input scaling selects 1, 1/2, 1/4, 1/8
// - Start pulse at left/right/misc capture begin, latch at end
// - Noise/misc captures last their ten-bit length
// - Left/right captures last their ten-bit length
// - Noise gives one bit per capture, 16-bit word
// - Valid flag set at misc capture end, cleared by a read that returns it
// - Misc result readable beside valid flag
// - Period is sum of state lengths from first index to maximum index
// - Full enable with index six gives seven states
`timescale 1ns/100ps
`default_nettype none
module adc_auto_sequencer import adc_seq_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic [14:0] conv_data,
	input wire logic noise_bit,
	output logic converter_power_down_q,
	output logic conv_clk_tick_q,
	output logic conv_start_q,
	output logic conv_diff_q,
	output logic [3:0] conv_ain_p_q,
	output logic [3:0] conv_ain_n_q,
	output logic [1:0] conv_vref_q,
	output logic [1:0] conv_res_q,
	output logic [3:0] conv_tsamp_q,
	output logic [1:0] input_scaling_select_q
);
	logic [31:0] ctrl_q, len_q;
	logic [31:0] cfg_q [0:2];
	logic [14:0] misc_data_q, left_data_q, right_data_q, rng_buf_q;
	logic sample_valid_flag_q;
	logic [14:0] data_s1_q, data_s2_q;
	logic noise_s1_q, noise_s2_q;
	seq_state_e st_q;
	step_e cur_q;
	logic [2:0] idx_q;
	logic [9:0] cnt_q;

	// Steps of the sequence, in order
	function automatic step_e step_of(input logic [2:0] idx,
		input logic [6:0] mask);
		logic [2:0] n;
		logic [2:0] res;
		n = 3'h1;
		res = 3'h0;
		// Spare indices fall back to the first enabled channel step
		for (int k = 6; k > 0; k--) begin
			if (mask[k]) begin
				res = 3'(k);
			end
		end
		// Noise owns index zero; the other steps pack from index one
		for (int k = 1; k < 7; k++) begin
			if (mask[k]) begin
				if (n == idx) begin
					res = 3'(k);
				end
				n = n + 3'h1;
			end
		end
		if (idx == 3'h0) begin
			res = 3'h0;
		end
		return step_e'(res);
	endfunction

	function automatic logic is_cap(input step_e s);
		return s == STEP_NOISE_CAP || s == STEP_LEFT_CAP ||
			s == STEP_RIGHT_CAP || s == STEP_MISC_CAP;
	endfunction

	function automatic logic [1:0] ch_of(input step_e s);
		if (s == STEP_LEFT_SET || s == STEP_LEFT_CAP) begin
			return 2'd0;
		end else if (s == STEP_RIGHT_SET || s == STEP_RIGHT_CAP) begin
			return 2'd1;
		end
		return 2'd2;
	endfunction

	// Extend a result from its resolution to the full word width
	function automatic logic [14:0] sext(input logic [14:0] raw,
		input logic [1:0] res);
		int w;
		logic [14:0] o;
		w = RES_BASE_BITS + 2 * int'(res);
		o = raw;
		for (int i = 0; i < DATA_BITS; i++) begin
			if (i >= w) begin
				o[i] = raw[w - 1];
			end
		end
		return o;
	endfunction

	// Control fields
	wire pd = ctrl_q[CTRL_PD];
	wire [2:0] clk_div = ctrl_q[CTRL_DIV_LSB +: 3];
	wire [2:0] max_idx = ctrl_q[CTRL_MAX_LSB +: 3];
	wire [3:0] en = ctrl_q[CTRL_EN_LSB +: 4];
	wire [3:0] set_len = ctrl_q[CTRL_SETLEN_LSB +: 4];
	wire [9:0] nm_len = len_q[LEN_NM_LSB +: 10];
	wire [9:0] lr_len = len_q[LEN_LR_LSB +: 10];
	wire en_noise = en[EN_NOISE];
	wire en_left = en[EN_LEFT];
	wire en_misc = en[EN_MISC];
	wire en_right = en[EN_RIGHT] && en_left;
	wire [6:0] step_mask = {en_misc, en_misc, en_right, en_right, en_left,
		en_left, en_noise};
	wire run_ok = !pd && (|step_mask);

	// APB decode; answer is one access cycle after setup, no wait states
	wire setup = psel && !penable;
	wire done = psel && penable && pready_q;
	wire wr = done && pwrite;
	wire rd_done = done && !pwrite;
	wire hit = paddr == ADDR_CTRL || paddr == ADDR_LEN ||
		paddr == ADDR_CFG_L || paddr == ADDR_CFG_R || paddr == ADDR_CFG_M ||
		paddr == ADDR_MISC || paddr == ADDR_RNG || paddr == ADDR_LR ||
		paddr == ADDR_STAT;
	wire [31:0] stat_word = {24'h0, cur_q, idx_q, 1'b0, st_q == ST_RUN};
	wire [31:0] rd_word =
		paddr == ADDR_CTRL ? ctrl_q :
		paddr == ADDR_LEN ? len_q :
		paddr == ADDR_CFG_L ? cfg_q[0] :
		paddr == ADDR_CFG_R ? cfg_q[1] :
		paddr == ADDR_CFG_M ? cfg_q[2] :
		paddr == ADDR_MISC ? {16'h0, sample_valid_flag_q, misc_data_q} :
		paddr == ADDR_RNG ? {16'h0, rng_buf_q, noise_s2_q} :
		paddr == ADDR_LR ? {1'b0, right_data_q, 1'b0, left_data_q} :
		paddr == ADDR_STAT ? stat_word : 32'h0;

	// Bus slave: read data captured in setup so it is a flop at the port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			prdata_q <= setup && !pwrite ? rd_word : 32'h0;
		end
	end

	// Writable registers; power-down set at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			len_q <= LEN_RESET;
			for (int i = 0; i < 3; i++) begin
				cfg_q[i] <= CFG_RESET;
			end
		end else if (wr) begin
			if (paddr == ADDR_CTRL) ctrl_q <= pwdata & CTRL_WMASK;
			if (paddr == ADDR_LEN) len_q <= pwdata & LEN_WMASK;
			if (paddr == ADDR_CFG_L) cfg_q[0] <= pwdata & CFG_WMASK;
			if (paddr == ADDR_CFG_R) cfg_q[1] <= pwdata & CFG_WMASK;
			if (paddr == ADDR_CFG_M) cfg_q[2] <= pwdata & CFG_WMASK;
		end
	end

	// Converter returns data and noise from its own timing: synchronise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_s1_q <= 15'h0;
			data_s2_q <= 15'h0;
			noise_s1_q <= 1'b0;
			noise_s2_q <= 1'b0;
		end else begin
			data_s1_q <= conv_data;
			data_s2_q <= data_s1_q;
			noise_s1_q <= noise_bit;
			noise_s2_q <= noise_s1_q;
		end
	end

	logic tick24, conv_tick;
	rate_ticks u_ticks (
		.pclk(pclk),
		.presetn(presetn),
		.clk_div(clk_div),
		.tick24(tick24),
		.conv_tick(conv_tick)
	);

	// State length in crystal ticks; zero behaves as one
	wire [9:0] cur_len = !is_cap(cur_q) ? {6'h0, set_len} :
		(cur_q == STEP_LEFT_CAP || cur_q == STEP_RIGHT_CAP) ?
		lr_len : nm_len;
	wire last = {1'b0, cnt_q} + 11'h1 >= {1'b0, cur_len};
	wire adv = st_q == ST_RUN && run_ok && tick24 && last;
	wire [2:0] wrap_idx = {2'b00, !en_noise}; // Index zero unused without noise
	wire [2:0] next_idx = (st_q == ST_IDLE || idx_q >= max_idx) ? wrap_idx :
		idx_q + 3'h1;
	wire step_e next_step = step_of(next_idx, step_mask);
	wire enter = (st_q == ST_IDLE && run_ok) || adv;
	wire [31:0] next_cfg = cfg_q[ch_of(next_step)];
	wire [1:0] cur_res = cfg_q[ch_of(cur_q)][CFG_RES_LSB +: 2];
	wire [14:0] result = sext(data_s2_q, cur_res);

	// Sequencer: index, current step and tick counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			idx_q <= 3'h0;
			cur_q <= STEP_NOISE_CAP;
			cnt_q <= 10'h0;
		end else if (!run_ok) begin
			st_q <= ST_IDLE;
			idx_q <= 3'h0;
			cnt_q <= 10'h0;
		end else if (enter) begin
			st_q <= ST_RUN;
			idx_q <= next_idx;
			cur_q <= next_step;
			cnt_q <= 10'h0;
		end else if (tick24) begin
			cnt_q <= cnt_q + 10'h1;
		end
	end

	// Set state applies channel controls; capture begin fires start, except for noise capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_start_q <= 1'b0;
			conv_diff_q <= 1'b0;
			conv_ain_p_q <= 4'h0;
			conv_ain_n_q <= 4'h0;
			conv_vref_q <= 2'h0;
			conv_res_q <= 2'h0;
			conv_tsamp_q <= 4'h0;
		end else begin
			conv_start_q <= enter && run_ok && is_cap(next_step) &&
				next_step != STEP_NOISE_CAP;
			if (enter && run_ok && !is_cap(next_step)) begin
				conv_diff_q <= next_cfg[CFG_DIFF];
				conv_ain_p_q <= next_cfg[CFG_AIN_P_LSB +: 4];
				conv_ain_n_q <= next_cfg[CFG_AIN_N_LSB +: 4];
				conv_vref_q <= next_cfg[CFG_VREF_LSB +: 2];
				conv_res_q <= next_cfg[CFG_RES_LSB +: 2];
				conv_tsamp_q <= next_cfg[CFG_TSAMP_LSB +: 4];
			end
		end
	end

	// Global converter controls follow their fields every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_power_down_q <= 1'b1;
			conv_clk_tick_q <= 1'b0;
			input_scaling_select_q <= 2'h0;
		end else begin
			converter_power_down_q <= pd;
			conv_clk_tick_q <= conv_tick && !pd;
			input_scaling_select_q <= ctrl_q[CTRL_SCALE_LSB +: 2];
		end
	end

	// Capture end latches; a read clears only the flag that it returned
	wire misc_end = adv && cur_q == STEP_MISC_CAP;
	wire valid_clr = rd_done && paddr == ADDR_MISC && prdata_q[15];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_data_q <= 15'h0;
			left_data_q <= 15'h0;
			right_data_q <= 15'h0;
			rng_buf_q <= 15'h0;
			sample_valid_flag_q <= 1'b0;
		end else begin
			if (misc_end) misc_data_q <= result;
			if (adv && cur_q == STEP_LEFT_CAP) left_data_q <= result;
			if (adv && cur_q == STEP_RIGHT_CAP) right_data_q <= result;
			if (adv && cur_q == STEP_NOISE_CAP) begin
				rng_buf_q <= {rng_buf_q[13:0], noise_s2_q};
			end
			if (misc_end) begin
				sample_valid_flag_q <= 1'b1;
			end else if (valid_clr) begin
				sample_valid_flag_q <= 1'b0;
			end
		end
	end

	// Crystal ticks since the last converter clock, for checking; a divider
	// change leaves the count unknown (4'hf) until the next converter clock
	logic [3:0] gap_q;
	logic [2:0] div_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 4'hf;
			div_seen_q <= 3'h0;
		end else begin
			div_seen_q <= clk_div;
			if (clk_div != div_seen_q) begin
				gap_q <= 4'hf;
			end else if (conv_tick) begin
				gap_q <= 4'h0;
			end else if (tick24 && gap_q != 4'hf) begin
				gap_q <= gap_q + 4'h1;
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pd_release:
	assert property (wr && paddr == ADDR_CTRL && !pwdata[CTRL_PD]
		|=> ##1 !converter_power_down_q) else $error("power-up late");
	a_pd_hold:
	assert property (pd |=> converter_power_down_q && !conv_start_q)
		else $error("converter active while down");
	a_div_ratio:
	assert property (conv_tick && clk_div == div_seen_q && gap_q != 4'hf
		|-> gap_q == {1'b0, clk_div}) else $error("divider ratio");
	a_noise_first:
	assert property (enter && run_ok && next_idx == 3'h0 && en_noise
		|=> cur_q == STEP_NOISE_CAP && idx_q == 3'h0)
		else $error("noise capture not state zero");
	a_wrap_zero:
	assert property (adv && idx_q >= max_idx && run_ok
		|=> idx_q == {2'b00, !$past(en_noise)})
		else $error("no wrap to first index");
	a_right_gate:
	assert property (enter && run_ok && !en_left
		|=> cur_q != STEP_RIGHT_SET && cur_q != STEP_RIGHT_CAP)
		else $error("right ran without left");
	a_set_length:
	assert property (adv && !is_cap(cur_q) && $stable(set_len)
		|-> cnt_q + 10'h1 >= {6'h0, set_len})
		else $error("set state too short");
	a_start_pulse:
	assert property (conv_start_q |-> is_cap(cur_q) &&
		cur_q != STEP_NOISE_CAP ##1 !conv_start_q)
		else $error("start pulse wrong");
	a_valid_set:
	assert property (misc_end |=> sample_valid_flag_q &&
		misc_data_q == $past(result)) else $error("valid not set");
	a_apb_answer:
	assert property (setup |=> pready_q ##1 !pready_q)
		else $error("bus answer timing");

	c_wrap: cover property (adv && idx_q == 3'h6 ##1 idx_q == 3'h0);
	c_valid_read: cover property (misc_end ##[1:300] valid_clr);
	c_right_start: cover property (conv_start_q && cur_q == STEP_RIGHT_CAP);
endmodule
`default_nettype wire

// ---- hw/adc_seq_pkg.sv ----
package adc_seq_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LEN = 8'h04;
	localparam logic [7:0] ADDR_CFG_L = 8'h08;
	localparam logic [7:0] ADDR_CFG_R = 8'h0c;
	localparam logic [7:0] ADDR_CFG_M = 8'h10;
	localparam logic [7:0] ADDR_MISC = 8'h14;
	localparam logic [7:0] ADDR_RNG = 8'h18;
	localparam logic [7:0] ADDR_LR = 8'h1c;
	localparam logic [7:0] ADDR_STAT = 8'h20;
	// Control word fields
	localparam int CTRL_PD = 0;
	localparam int CTRL_DIV_LSB = 1;
	localparam int CTRL_MAX_LSB = 4;
	localparam int CTRL_EN_LSB = 8;
	localparam int CTRL_SETLEN_LSB = 12;
	localparam int CTRL_SCALE_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK = 32'h0003_ff7f;
	// Channel enable bit positions within the enable field
	localparam int EN_LEFT = 0;
	localparam int EN_RIGHT = 1;
	localparam int EN_MISC = 2;
	localparam int EN_NOISE = 3;
	// Capture length word fields
	localparam int LEN_NM_LSB = 0;
	localparam int LEN_LR_LSB = 16;
	localparam logic [31:0] LEN_RESET = 32'h0000_0000;
	localparam logic [31:0] LEN_WMASK = 32'h03ff_03ff;
	// Per-channel configuration word fields; misc valid bit position
	localparam int CFG_AIN_N_LSB = 0;
	localparam int CFG_AIN_P_LSB = 4;
	localparam int CFG_DIFF = 8;
	localparam int CFG_VREF_LSB = 9;
	localparam int CFG_RES_LSB = 12;
	localparam int CFG_TSAMP_LSB = 16;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK = 32'h000f_37ff;
	localparam int MISC_VALID = 15;
	// Reference crystal and bus clock rates, result widths
	localparam int XTAL_MHZ = 24;
	localparam int PCLK_MHZ = 125;
	localparam int RES_BASE_BITS = 8;
	localparam int DATA_BITS = 15;
	// Sequence steps in fixed order
	typedef enum logic [2:0] {
		STEP_NOISE_CAP, STEP_LEFT_SET, STEP_LEFT_CAP, STEP_RIGHT_SET,
		STEP_RIGHT_CAP, STEP_MISC_SET, STEP_MISC_CAP
	} step_e;
	typedef enum logic {ST_IDLE, ST_RUN} seq_state_e;
endpackage

// ---- hw/rate_ticks.sv ----
`timescale 1ns/100ps
`default_nettype none
module rate_ticks import adc_seq_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] clk_div,
	output logic tick24,
	output logic conv_tick
);
	localparam logic [7:0] ACC_STEP = 8'(XTAL_MHZ);
	localparam logic [7:0] ACC_WRAP = 8'(PCLK_MHZ);
	logic [7:0] acc_q;
	logic [7:0] acc_sum;
	logic [2:0] div_q;
	logic wrap;

	// Fractional accumulator: 24 ticks per 125 bus clocks, jitter one cycle
	assign acc_sum = acc_q + ACC_STEP;
	assign wrap = acc_sum >= ACC_WRAP;
	assign tick24 = wrap;
	assign conv_tick = wrap && (div_q >= clk_div);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 8'h00;
		end else begin
			acc_q <= wrap ? acc_sum - ACC_WRAP : acc_sum;
		end
	end

	// Converter clock period is clk_div+1 crystal ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 3'h0;
		end else if (wrap) begin
			div_q <= (div_q >= clk_div) ? 3'h0 : div_q + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ---- tb/conv_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Converter core and noise source facing the sequencer
module conv_core_model (
	input wire logic pclk,
	input wire logic conv_start,
	input wire logic [1:0] conv_res,
	input wire logic [14:0] sample,
	output logic [14:0] conv_data,
	output logic noise_bit
);
	logic [14:0] width_mask;
	logic [14:0] data_q = 15'h0;
	logic noise_q = 1'b0;
	// A real core drives only the bits of the chosen width
	assign width_mask = 15'h7fff >> (7 - 2 * int'(conv_res));
	assign conv_data = data_q;
	assign noise_bit = noise_q;
	// Result moves only at a start, so it is stable well before the latch
	always @(posedge pclk) begin
		noise_q <= ~noise_q;
		if (conv_start)
			data_q <= sample & width_mask;
	end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	import adc_seq_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_q, rdat;
	logic [14:0] conv_data, sample;
	logic noise_bit, converter_power_down_q, conv_clk_tick_q, conv_start_q;
	logic conv_diff_q;
	logic [3:0] conv_ain_p_q, conv_ain_n_q, conv_tsamp_q;
	logic [1:0] conv_vref_q, conv_res_q, input_scaling_select_q;
	int fails = 0, cmp_count = 0, cyc = 0, waited, ticks, starts;
	adc_auto_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .conv_data,
		.noise_bit, .converter_power_down_q, .conv_clk_tick_q, .conv_start_q,
		.conv_diff_q, .conv_ain_p_q, .conv_ain_n_q, .conv_vref_q, .conv_res_q,
		.conv_tsamp_q, .input_scaling_select_q);
	conv_core_model core_u (.pclk, .conv_start(conv_start_q),
		.conv_res(conv_res_q), .sample, .conv_data, .noise_bit);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cut a hang short; the whole run needs far fewer cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			stop_test;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the idle cycle after it keeps drivers single-valued
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Held until pready is sampled high; only the bench timeout ends it
		do begin
			@(posedge pclk);
		end while (pready_q !== 1'b1);
		rdat = prdata_q;
		rerr = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_start(input int lim);
		waited = 0;
		do begin
			@(posedge pclk);
			waited++;
		end while (conv_start_q !== 1'b1 && waited < lim);
	endtask
	task automatic count(input int n);
		ticks = 0;
		starts = 0;
		repeat (n) begin
			@(posedge pclk);
			ticks += int'(conv_clk_tick_q === 1'b1);
			starts += int'(conv_start_q === 1'b1);
		end
	endtask
	task t_reset;
		chk(converter_power_down_q, 1);
		apb(0, ADDR_CTRL, 0);
		chk(rdat, CTRL_RESET);
		apb(0, 8'h24, 0);
		chk(rerr, 1);
		chk(rdat, 0);
		// Channels enabled while still powered down must stay quiet
		apb(1, ADDR_CTRL, 32'h0000_0f61);
		count(300);
		chk(ticks + starts, 0);
		$display("test reset done");
	endtask
	task t_clock;
		int e;
		for (int d = 1; d < 8; d += 3) begin
			apb(1, ADDR_CTRL, d << 1);
			count(1250);
			e = 240 / (d + 1);
			chk(ticks >= e - 1 && ticks <= e + 1, 1);
			chk(converter_power_down_q, 0);
		end
		$display("test clock done");
	endtask
	task t_misc;
		logic [14:0] m, e;
		sample = 15'h2aaa;
		apb(1, ADDR_LEN, 32'h002c_0014);
		apb(1, ADDR_CTRL, 32'h0002_4420);
		for (int r = 0; r < 4; r++) begin
			apb(1, ADDR_CFG_M, 32'h0005_05a3 | (r << 12));
			wait_start(400);
			wait_start(400);
			chk(waited, 125);
			chk({conv_diff_q, conv_ain_p_q, conv_ain_n_q, conv_vref_q,
				conv_tsamp_q}, {1'b1, 4'ha, 4'h3, 2'h2, 4'h5});
			chk(conv_res_q, r);
			chk(input_scaling_select_q, 2);
			m = 15'h7fff >> (7 - 2 * r);
			e = sample[7 + 2 * r] ? (sample | ~m) : (sample & m);
			repeat (115) @(posedge pclk);
			apb(0, ADDR_MISC, 0);
			chk(rdat, {16'h1, e});
			apb(0, ADDR_MISC, 0);
			chk(rdat[15], 0);
		end
		$display("test misc done");
	endtask
	task t_left;
		apb(1, ADDR_CTRL, 32'h0000_4120);
		wait_start(600);
		wait_start(600);
		chk(waited, 250);
		repeat (240) @(posedge pclk);
		apb(0, ADDR_LR, 0);
		chk(rdat[14:0], 15'h7faa);
		$display("test left done");
	endtask
	task t_right;
		logic [31:0] rng;
		// Right alone must not start a sequence
		apb(1, ADDR_CTRL, 32'h0000_0220);
		count(400);
		chk(starts, 0);
		apb(0, ADDR_STAT, 0);
		chk(rdat[0], 0);
		// Idle: buffered bits hold, the live bit flips over three cycles
		apb(0, ADDR_RNG, 0);
		rng = rdat;
		apb(0, ADDR_RNG, 0);
		chk(rdat, {rng[31:1], ~rng[0]});
		$display("test right done");
	endtask
	task automatic t_order(input logic [3:0] en, input int mx,
		input logic [20:0] seq);
		int k, n, i, first;
		logic [2:0] last;
		k = 0;
		n = 0;
		// Noise owns index zero; without it the sequence starts at one
		first = en[EN_NOISE] ? 0 : 1;
		i = first;
		apb(1, ADDR_LEN, 32'h0006_0006);
		apb(1, ADDR_CTRL, 32'h3000 | (en << 8) | (mx << 4));
		do begin
			apb(0, ADDR_STAT, 0);
			n++;
		end while (rdat[7:5] !== seq[3 * first +: 3] && n < 100);
		last = rdat[7:5];
		// Two laps prove the wrap back to the first index
		while (k < 2 * (mx + 1 - first) && n < 400) begin
			apb(0, ADDR_STAT, 0);
			n++;
			if (rdat[7:5] !== last) begin
				k++;
				i = (i >= mx) ? first : i + 1;
				chk({rdat[7:2], rdat[0]}, {seq[3 * i +: 3], 3'(i),
					1'b1});
				last = rdat[7:5];
			end
		end
		chk(k, 2 * (mx + 1 - first));
		$display("test order done");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sample = 15'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_clock;
		t_misc;
		t_left;
		t_right;
		// Enable patterns with matching maximum index
		t_order(4'hf, 6, 21'o6543210);
		t_order(4'hd, 4, 21'o65210);
		t_order(4'h3, 4, 21'o43210);
		t_order(4'hc, 2, 21'o650);
		stop_test;
	end
endmodule
`default_nettype wire
